// ---- test/pdsi_regs_props.sv ----
// assertion checker for the port register bank
module pdsi_regs_props
  import pdsi_pkg::*;
(
  // clock and reset
  input wire logic               clk,
  input wire logic               rst_n,
  // apb slave
  input wire logic [ADDR_W-1:0]  paddr,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [DATA_W-1:0]  pwdata,
  input wire logic [DATA_W-1:0]  prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // cable test engine
  input wire pdsi_ct_req_t       ctReq,
  input wire pdsi_ct_rsp_t       ctRsp,
  // line status, events and interrupt
  input wire logic               linkUp1000,
  input wire logic               linkUp100,
  input wire logic               symErrFrame,
  input wire logic [NUM_EVT-1:0] portEvent,
  input wire logic               irqOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic acc;
  logic wrCable;
  logic accIrq;
  assign acc     = psel && penable && pready;
  assign wrCable = acc && pwrite && paddr == OFS_CABLE;
  assign accIrq  = acc && paddr == OFS_IRQ;
  // quiet read phase: no event may land while the clear is in flight
  sequence s_rd(a, e, en);
    psel && penable == en && !pwrite && paddr == a && !e;
  endsequence
  property p_start;
    ctReq.start |-> $past(wrCable && pwdata[CT_RUN_BIT]);
  endproperty
  property p_abort;
    ctReq.abort |-> $past(wrCable && !pwdata[CT_RUN_BIT]);
  endproperty
  property p_pair;
    wrCable |=> ctReq.pair == $past(pwdata[CT_PAIR_HI:CT_PAIR_LO]);
  endproperty
  property p_result;
    acc && !pwrite && paddr == OFS_CABLE |-> prdata[CT_STAT_HI:CT_STAT_LO] != 2'h3;
  endproperty
  property p_link;
    acc && !pwrite && paddr == OFS_LINK |-> prdata[1:0] == {$past(linkUp1000, 2), $past(linkUp100, 2)};
  endproperty
  property p_cntClr;
    s_rd(OFS_SYMERR, symErrFrame, 1'b0) ##1 s_rd(OFS_SYMERR, symErrFrame, 1'b1)
      ##1 s_rd(OFS_SYMERR, symErrFrame, 1'b0) |=> prdata[15:0] == 16'h0000;
  endproperty
  property p_flgClr;
    s_rd(OFS_IRQ, portEvent, 1'b0) ##1 s_rd(OFS_IRQ, portEvent, 1'b1)
      ##1 s_rd(OFS_IRQ, portEvent, 1'b0) |=> prdata[7:0] == 8'h00;
  endproperty
  property p_irqFall;
    $fell(irqOut) |-> $past(accIrq) || $past(accIrq, 2) || $past(accIrq, 3);
  endproperty
  property p_rst;
    $rose(rst_n) |-> !irqOut && ctReq == '0;
  endproperty
  a_start: assert property (p_start) else $error("start pulse without launching write");
  a_abort: assert property (p_abort) else $error("abort pulse without stopping write");
  a_pair: assert property (p_pair) else $error("pair select not taken from write");
  a_result: assert property (p_result) else $error("reserved result code read");
  a_link: assert property (p_link) else $error("link bits differ from inputs");
  a_cntClr: assert property (p_cntClr) else $error("count not cleared by read");
  a_flgClr: assert property (p_flgClr) else $error("flags not cleared by read");
  a_irqFall: assert property (p_irqFall) else $error("interrupt dropped with no access");
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  c_start: cover property (ctReq.start);
  c_abort: cover property (ctReq.abort);
  c_irq: cover property ($rose(irqOut));
endmodule

bind pdsi_regs pdsi_regs_props u_props (.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
  .pready, .pslverr, .ctReq, .ctRsp, .linkUp1000, .linkUp100, .symErrFrame, .portEvent, .irqOut);

// ---- test/pdsi_regs_tb.sv ----
// self-checking bench for the port register bank
module pdsi_regs_tb
  import pdsi_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic               clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic               linkUp1000, linkUp100, symErrFrame, irqOut;
  logic [ADDR_W-1:0]  paddr;
  logic [DATA_W-1:0]  pwdata, prdata, rdat;
  logic [NUM_EVT-1:0] portEvent;
  pdsi_ct_req_t       ctReq;
  pdsi_ct_rsp_t       ctRsp;
  int                 failures, n_tests;

  pdsi_regs dut (.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .ctReq, .ctRsp, .linkUp1000, .linkUp100, .symErrFrame, .portEvent, .irqOut);

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // expected register words, built from the field positions
  function automatic logic [31:0] cable_word(input logic run, input logic [1:0] pr, input logic [1:0] st);
    logic [31:0] w;
    w = '0;
    w[CT_RUN_BIT] = run;
    w[CT_PAIR_HI:CT_PAIR_LO] = pr;
    w[CT_STAT_HI:CT_STAT_LO] = st;
    return w;
  endfunction

  function automatic logic [31:0] irq_word(input logic [7:0] en, input logic [7:0] flg);
    logic [31:0] w;
    w = '0;
    w[IRQ_EN_LO+:NUM_EVT] = en;
    w[IRQ_FLG_LO+:NUM_EVT] = flg;
    return w;
  endfunction

  // request stays up after the answer so a second transfer can follow at once
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk("pready", 1, 0);
    rdat = prdata;
    err = pslverr;
  endtask

  task automatic rel();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    xfer(1'b0, a, 32'h0);
    rel();
    chk(nm, exp, rdat);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    rel();
  endtask

  task automatic pulse(input logic [7:0] ev);
    portEvent <= ev;
    @(posedge clk);
    portEvent <= 8'h00;
    repeat (3) @(posedge clk);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #250000;
    failures++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    logic [1:0] p;
    logic [1:0] r;
    logic [1:0] q;
    logic [7:0] m;
    int         n;
    {rst_n, psel, penable, pwrite, linkUp1000, linkUp100, symErrFrame} = '0;
    paddr = '0;
    pwdata = '0;
    portEvent = '0;
    ctRsp = '0;
    failures = 0;
    n_tests = 0;
    q = STAT_RST;
    void'($urandom(32'h1e53e895));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(OFS_CABLE, 32'h0, "cable reset");
    rd(OFS_SYMERR, 32'h0, "count reset");
    rd(OFS_IRQ, 32'h0, "irq reset");
    chk("mapped err", 0, 32'(err));
    rd(12'h010, 32'h0, "unmapped data");
    chk("unmapped err", 1, 32'(err));
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      linkUp1000 <= i[1];
      linkUp100 <= i[0];
      repeat (3) @(posedge clk);
      rd(OFS_LINK, 32'(i), "link");
    end
    $display("test link done");
    n = $urandom_range(40, 1);
    symErrFrame <= 1'b1;
    repeat (n) @(posedge clk);
    symErrFrame <= 1'b0;
    wr(OFS_SYMERR, 32'hffff);
    xfer(1'b0, OFS_SYMERR, 32'h0);
    chk("count", 32'(n), rdat);
    xfer(1'b0, OFS_SYMERR, 32'h0);
    rel();
    chk("count clear", 32'h0, rdat);
    $display("test count done");
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << i;
      wr(OFS_IRQ, irq_word(m, 8'hff));
      pulse({m[6:0], m[7]});
      chk("masked", 0, 32'(irqOut));
      pulse(m);
      chk("irq on", 1, 32'(irqOut));
      xfer(1'b0, OFS_IRQ, 32'h0);
      chk("flags", irq_word(m, m | {m[6:0], m[7]}), rdat);
      xfer(1'b0, OFS_IRQ, 32'h0);
      rel();
      chk("flags clear", irq_word(m, 8'h00), rdat);
      repeat (2) @(posedge clk);
      chk("irq off", 0, 32'(irqOut));
    end
    $display("test interrupt done");
    for (int k = 0; k < 12; k++) begin
      p = k[1:0];
      r = k[3:2];
      wr(OFS_CABLE, cable_word(1'b1, p, 2'h0));
      chk("start", 1, 32'(ctReq.start));
      chk("pair", 32'(p), 32'(ctReq.pair));
      rd(OFS_CABLE, cable_word(1'b1, p, q), "busy");
      repeat ($urandom_range(30, 1)) @(posedge clk);
      ctRsp <= '{done: 1'b1, result: r};
      @(posedge clk);
      ctRsp <= '0;
      rd(OFS_CABLE, cable_word(1'b0, p, r), "result");
      q = r;
    end
    wr(OFS_CABLE, cable_word(1'b1, PAIR_B, 2'h0));
    wr(OFS_CABLE, cable_word(1'b1, PAIR_D, 2'h0));
    chk("no restart", 0, 32'(ctReq.start));
    chk("pair while busy", 32'(PAIR_D), 32'(ctReq.pair));
    rd(OFS_CABLE, cable_word(1'b1, PAIR_D, q), "still busy");
    ctRsp <= '{done: 1'b1, result: STAT_OPEN};
    @(posedge clk);
    ctRsp <= '{done: 1'b1, result: STAT_SHORT};
    @(posedge clk);
    ctRsp <= '0;
    rd(OFS_CABLE, cable_word(1'b0, PAIR_D, STAT_OPEN), "late done");
    q = STAT_OPEN;
    wr(OFS_CABLE, cable_word(1'b1, PAIR_A, 2'h0));
    wr(OFS_CABLE, 32'h0000);
    chk("abort", 1, 32'(ctReq.abort));
    rd(OFS_CABLE, cable_word(1'b0, PAIR_A, q), "aborted");
    $display("test cable done");
    finish_test();
  end
endmodule

// ---- verilog/pdsi_pkg.sv ----
// constants, field layout and carrier types of the port diagnostic, status and interrupt registers
// Summary of operation
// - Writing one to bit 15 of the cable diagnostic register when idle launches a test on the selected pair, and the bit clears itself when the test ends.
// - Bit 15 reads one while a test runs; once it drops after a launch that was not aborted, the status field holds that test's result.
// - Writing zero to bit 15 stops the cable test instead of launching one.
// - Bits 13:12 pick the pair under test (00 A, 01 B, 10 C, 11 D) and reset to 00.
// - Read-only bits 9:8 give the result: 00 normal, 01 open, 10 short, 11 reserved.
// - The link status register shows the gigabit link in bit 1 and the 100 Mb/s link in bit 0, one meaning up.
// - A 16-bit read-only counter counts received frames with a symbol error, resets to zero and clears when read.
// - Enable bits 15 to 8 govern jabber, receive error, page received, parallel detect fault, partner acknowledge, link down, remote fault and link up.
// - Status bits 7 to 0 flag the same eight events in the same order, one meaning the event occurred.
// - Each status flag is read-only and is cleared by reading its register.
// - After reset all eight enables and all eight flags are zero.
package pdsi_pkg;

  // bus geometry
  localparam int          ADDR_W      = 12;
  localparam int          DATA_W      = 32;
  localparam int          REG_W       = 16;
  localparam int          NUM_EVT     = 8;

  // register byte offsets
  localparam logic [11:0] OFS_CABLE   = 12'h000;
  localparam logic [11:0] OFS_LINK    = 12'h004;
  localparam logic [11:0] OFS_SYMERR  = 12'h008;
  localparam logic [11:0] OFS_IRQ     = 12'h00c;

  // cable diagnostic field positions
  localparam int          CT_RUN_BIT  = 15;
  localparam int          CT_PAIR_HI  = 13;
  localparam int          CT_PAIR_LO  = 12;
  localparam int          CT_STAT_HI  = 9;
  localparam int          CT_STAT_LO  = 8;

  // link status field positions
  localparam int          LINK_1G_BIT = 1;
  localparam int          LINK_FE_BIT = 0;

  // interrupt register field positions
  localparam int          IRQ_EN_LO   = 8;
  localparam int          IRQ_FLG_LO  = 0;

  // event order inside both interrupt bytes
  localparam int          EVT_JABBER  = 7;
  localparam int          EVT_RXERR   = 6;
  localparam int          EVT_PAGE    = 5;
  localparam int          EVT_PDFAULT = 4;
  localparam int          EVT_LPACK   = 3;
  localparam int          EVT_LINKDN  = 2;
  localparam int          EVT_RFAULT  = 1;
  localparam int          EVT_LINKUP  = 0;

  // cable diagnostic pair and result codes
  localparam logic [1:0]  PAIR_A      = 2'h0;
  localparam logic [1:0]  PAIR_B      = 2'h1;
  localparam logic [1:0]  PAIR_C      = 2'h2;
  localparam logic [1:0]  PAIR_D      = 2'h3;
  localparam logic [1:0]  STAT_NORMAL = 2'h0;
  localparam logic [1:0]  STAT_OPEN   = 2'h1;
  localparam logic [1:0]  STAT_SHORT  = 2'h2;

  // reset values and counter ceiling
  localparam logic [1:0]  PAIR_RST    = PAIR_A;
  localparam logic [1:0]  STAT_RST    = STAT_NORMAL;
  localparam logic [15:0] CNT_RST     = 16'h0000;
  localparam logic [15:0] CNT_MAX     = 16'hffff;
  localparam logic [7:0]  EN_RST      = 8'h00;
  localparam logic [7:0]  FLG_RST     = 8'h00;
  localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

  // cable test engine request: start and abort are one-cycle pulses, pair is a level
  typedef struct packed {
    logic       start;
    logic       abort;
    logic [1:0] pair;
  } pdsi_ct_req_t;

  // cable test engine answer: done is a one-cycle pulse carrying the result
  typedef struct packed {
    logic       done;
    logic [1:0] result;
  } pdsi_ct_rsp_t;

  typedef enum logic {
    CT_IDLE,
    CT_RUN
  } pdsi_ct_state_t;

endpackage

// ---- verilog/pdsi_regs.sv ----
// apb register bank for cable diagnostics, link status, symbol error count and port interrupts
module pdsi_regs
  import pdsi_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // apb slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // cable test engine
  output pdsi_ct_req_t           ctReq,
  input  wire pdsi_ct_rsp_t      ctRsp,
  // line status and events
  input  wire logic              linkUp1000,
  input  wire logic              linkUp100,
  input  wire logic              symErrFrame,
  input  wire logic [NUM_EVT-1:0] portEvent,
  // interrupt
  output logic                   irqOut
);

  // bus phase decode
  logic              setupPh;
  logic              accessPh;
  logic              wrAcc;
  logic              rdAcc;
  logic              hitCable;
  logic              hitLink;
  logic              hitSymErr;
  logic              hitIrq;
  logic              mapped;
  logic              wrCableAcc;
  logic              wrIrqAcc;
  logic              rdSymClr;
  logic              rdIrqClr;

  // bus answer registers
  logic [DATA_W-1:0] prdata_q;
  logic [DATA_W-1:0] prdata_d;
  logic              pready_q;
  logic              pready_d;
  logic              pslverr_q;
  logic              pslverr_d;
  logic [DATA_W-1:0] rdMux;

  // cable diagnostic state
  pdsi_ct_state_t    ctState_q;
  pdsi_ct_state_t    ctState_d;
  logic [1:0]        pair_q;
  logic [1:0]        pair_d;
  logic [1:0]        ctStat_q;
  logic [1:0]        ctStat_d;
  pdsi_ct_req_t      ctReq_q;
  pdsi_ct_req_t      ctReq_d;

  // link status
  logic              link1g_q;
  logic              link1g_d;
  logic              linkFe_q;
  logic              linkFe_d;

  // symbol error frame counter
  logic [REG_W-1:0]  symCnt_q;
  logic [REG_W-1:0]  symCnt_d;
  logic [REG_W-1:0]  symCntLeft;

  // interrupt enables, flags and output
  logic [NUM_EVT-1:0] irqEn_q;
  logic [NUM_EVT-1:0] irqEn_d;
  logic [NUM_EVT-1:0] irqFlags;
  logic [NUM_EVT-1:0] flagClr;
  logic               irq_q;
  logic               irq_d;

  // bus decode

  assign setupPh   = psel && !penable;
  // pready is raised for exactly the first access cycle, so each transfer has no wait state
  assign accessPh  = psel && penable && pready_q;
  assign wrAcc     = accessPh && pwrite;
  assign rdAcc     = accessPh && !pwrite;
  assign hitCable  = (paddr == OFS_CABLE);
  assign hitLink   = (paddr == OFS_LINK);
  assign hitSymErr = (paddr == OFS_SYMERR);
  assign hitIrq    = (paddr == OFS_IRQ);
  assign mapped    = hitCable || hitLink || hitSymErr || hitIrq;

  // access-edge strobes at which a write lands or a clear-on-read takes effect
  assign wrCableAcc = wrAcc && hitCable;
  assign wrIrqAcc   = wrAcc && hitIrq;
  assign rdSymClr   = rdAcc && hitSymErr;
  assign rdIrqClr   = rdAcc && hitIrq;

  // read view of every register, upper bits read as zero
  always_comb begin
    rdMux = '0;
    if (hitCable) begin
      // reserved bits 14 and 11:10 read as zero
      rdMux[CT_RUN_BIT]             = (ctState_q == CT_RUN);
      rdMux[CT_PAIR_HI:CT_PAIR_LO]  = pair_q;
      rdMux[CT_STAT_HI:CT_STAT_LO]  = ctStat_q;
    end else if (hitLink) begin
      rdMux[LINK_1G_BIT]            = link1g_q;
      rdMux[LINK_FE_BIT]            = linkFe_q;
    end else if (hitSymErr) begin
      rdMux[REG_W-1:0]              = symCnt_q;
    end else if (hitIrq) begin
      rdMux[IRQ_EN_LO+NUM_EVT-1:IRQ_EN_LO]   = irqEn_q;
      rdMux[IRQ_FLG_LO+NUM_EVT-1:IRQ_FLG_LO] = irqFlags;
    end
  end

  // read data is captured in the setup cycle; the clear-on-read effects then remove
  // exactly what was captured, so anything arriving in between stays visible
  always_comb begin
    prdata_d  = prdata_q;
    pready_d  = setupPh;
    // unmapped offsets answer with an error and zero data, writes to them are dropped
    pslverr_d = setupPh && !mapped;
    if (setupPh) begin
      if (pwrite) begin
        // writes return zero read data
        prdata_d = RDATA_RST;
      end else begin
        prdata_d = rdMux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_q  <= RDATA_RST;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // cable diagnostic

  always_comb begin
    ctState_d     = ctState_q;
    pair_d        = pair_q;
    ctStat_d      = ctStat_q;
    ctReq_d       = ctReq_q;
    ctReq_d.start = 1'b0;
    ctReq_d.abort = 1'b0;
    case (ctState_q)
      CT_IDLE: begin
        // the pair follows every write, running or not
        if (wrCableAcc) begin
          pair_d = pwdata[CT_PAIR_HI:CT_PAIR_LO];
          if (pwdata[CT_RUN_BIT]) begin
            // launch on the pair written in the same access
            ctState_d     = CT_RUN;
            ctReq_d.start = 1'b1;
          end
        end
      end
      CT_RUN: begin
        if (ctRsp.done) begin
          // result is stored on the same edge as the run bit drops, so a zero read always sees it
          ctStat_d  = ctRsp.result;
          ctState_d = CT_IDLE;
        end else if (wrCableAcc && !pwdata[CT_RUN_BIT]) begin
          ctReq_d.abort = 1'b1;
          ctState_d     = CT_IDLE;
        end
        if (wrCableAcc) begin
          pair_d = pwdata[CT_PAIR_HI:CT_PAIR_LO];
        end
      end
      default: begin
        ctState_d = CT_IDLE;
      end
    endcase
    // the engine sees the selection as a level; it is only sampled on start
    ctReq_d.pair = pair_d;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctState_q <= CT_IDLE;
      pair_q    <= PAIR_RST;
      ctStat_q  <= STAT_RST;
      ctReq_q   <= '{start: 1'b0, abort: 1'b0, pair: PAIR_RST};
    end else begin
      ctState_q <= ctState_d;
      pair_q    <= pair_d;
      ctStat_q  <= ctStat_d;
      ctReq_q   <= ctReq_d;
    end
  end

  assign ctReq = ctReq_q;

  // link status

  // one register stage: a read returns the level of two edges before its access cycle
  always_comb begin
    link1g_d = linkUp1000;
    linkFe_d = linkUp100;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link1g_q <= 1'b0;
      linkFe_q <= 1'b0;
    end else begin
      link1g_q <= link1g_d;
      linkFe_q <= linkFe_d;
    end
  end

  // symbol error counter

  always_comb begin
    symCntLeft = symCnt_q;
    if (rdSymClr) begin
      // subtracting the captured value keeps frames counted between setup and access
      symCntLeft = symCnt_q - prdata_q[REG_W-1:0];
    end
    symCnt_d = symCntLeft;
    // saturates rather than wrapping, so a long unread interval never looks small
    if (symErrFrame && (symCntLeft != CNT_MAX)) begin
      symCnt_d = symCntLeft + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      symCnt_q <= CNT_RST;
    end else begin
      symCnt_q <= symCnt_d;
    end
  end

  // interrupts

  always_comb begin
    irqEn_d = irqEn_q;
    if (wrIrqAcc) begin
      // flag bits of the write data are ignored, flags are read-only
      irqEn_d = pwdata[IRQ_EN_LO+NUM_EVT-1:IRQ_EN_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irqEn_q <= EN_RST;
    end else begin
      irqEn_q <= irqEn_d;
    end
  end

  always_comb begin
    flagClr = '0;
    if (rdIrqClr) begin
      // only the flags that the read returned are cleared
      flagClr = prdata_q[IRQ_FLG_LO+NUM_EVT-1:IRQ_FLG_LO];
    end
  end

  pdsi_sticky_flags #(
    .W      (NUM_EVT)
  ) u_flags (
    .clk    (clk),
    .rst_n  (rst_n),
    .setVec (portEvent),
    .clrVec (flagClr),
    .flags  (irqFlags)
  );

  always_comb begin
    irq_d = |(irqFlags & irqEn_q);
  end

  // registered so the pin cannot glitch while flags and enables change together
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign irqOut = irq_q;

endmodule

// ---- verilog/pdsi_sticky_flags.sv ----
// bank of sticky event flags, a set in the same cycle as a clear wins
module pdsi_sticky_flags #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // event pulses and clear mask
  input  wire logic [W-1:0] setVec,
  input  wire logic [W-1:0] clrVec,
  // flag state
  output logic      [W-1:0] flags
);

  logic [W-1:0] flags_q;
  logic [W-1:0] flags_d;

  always_comb begin
    // a late event must not be lost to the read that clears its flag
    flags_d = (flags_q & ~clrVec) | setVec;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;

endmodule
